// ### inc/hwbp_regs.svh
`ifndef HWBP_REGS_SVH
`define HWBP_REGS_SVH
// ----------------------------------------
// Register offsets from the base address
// ----------------------------------------
`define HWBP_OFS_ADDR_LOW   4'h0
`define HWBP_OFS_ADDR_MID   4'h1
`define HWBP_OFS_ADDR_HIGH  4'h2
`define HWBP_OFS_ADDR_TOP   4'h3
`define HWBP_OFS_CMP_LOW    4'h4
`define HWBP_OFS_CMP_B1     4'h5
`define HWBP_OFS_CMP_B2     4'h6
`define HWBP_OFS_CMP_B3     4'h7
`define HWBP_OFS_CONTROL    4'hF
// ----------------------------------------
// Control register fields and reset values
// ----------------------------------------
`define HWBP_BIT_ENABLE     0
`define HWBP_BIT_DIR_SEL    1
`define HWBP_BIT_CMP_EN     2
`define HWBP_BIT_MATCH      3
`define HWBP_BIT_STATUS     7
`define HWBP_REG_RESET      8'h00
`define HWBP_BASE_DEFAULT   24'h0000D0
`define HWBP_REG_COUNT      16
`endif

// ### inc/hwbp_pkg.sv
package hwbp_pkg;
   typedef logic [7:0] hwbp_byte_type;
   typedef logic [3:0] hwbp_offset_type;
endpackage

// ### src/hwbp_regfile.sv
`include "hwbp_regs.svh"
// ----------------------------------------
// Byte register file, registered read data
// ----------------------------------------
module hwbp_regfile
   import hwbp_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic            wr_en,
   input  wire hwbp_offset_type wr_ofs,
   input  wire hwbp_byte_type   wr_data,
   input  wire hwbp_offset_type rd_ofs,
   output hwbp_byte_type        rd_data,
   output logic [23:0]          bp_addr,
   output hwbp_byte_type        cmp_value
);
   hwbp_byte_type mem [0:2];
   hwbp_byte_type cmp_low;
   logic          wr_mem;
   hwbp_byte_type next_rd_data;

   assign wr_mem    = wr_en && (wr_ofs <= `HWBP_OFS_ADDR_HIGH);
   assign bp_addr   = {mem[2], mem[1], mem[0]};
   assign cmp_value = cmp_low;
   // Reserved bytes read as zero and keep no storage.
   assign next_rd_data = (rd_ofs <= `HWBP_OFS_ADDR_HIGH) ? mem[rd_ofs[1:0]] :
                         (rd_ofs == `HWBP_OFS_CMP_LOW) ? cmp_low : 8'h00;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mem[0]  <= `HWBP_REG_RESET;
         mem[1]  <= `HWBP_REG_RESET;
         mem[2]  <= `HWBP_REG_RESET;
         cmp_low <= `HWBP_REG_RESET;
         rd_data <= 8'h00;
      end else begin
         if (wr_mem) begin
            mem[wr_ofs[1:0]] <= wr_data;
         end
         if (wr_en && wr_ofs == `HWBP_OFS_CMP_LOW) begin
            cmp_low <= wr_data;
         end
         rd_data <= next_rd_data;
      end
   end
endmodule

// ### src/hw_breakpoint_unit.sv
`include "hwbp_regs.svh"
// Function
// - Host debug port has eight two-way data lines and two handshake lines.
// - Monitor entry uses the processor non-maskable interrupt.
// - Host escape and breakpoint hit both merge onto the interrupt line.
// - Control bit 7 reads one after a breakpoint hit.
// - Status stays set until software writes zero to it.
// - Active-low analyzer trigger pulses low on each hit.
// - Registers decode as offsets from a board-chosen base address.
// - Breakpoint address bytes at offsets 0, 1, 2 hold bits 0-23.
// - Offset 3 is reserved and ignored by the compare.
// - Data compare byte sits at offset 4; offsets 5 to 7 reserved.
// - Offset 5 is reserved and unused by the comparator.
// - Control register sits at offset F.
// - Control bit 0 enables, bit 1 picks read, bit 2 enables data.
// - Control bit 3 selects equal data or different data.
// - Address compare covers the full processor address space.
// - A hit drives the interrupt low for exactly one cycle.
module hw_breakpoint_unit
   import hwbp_pkg::*;
#(
   parameter logic [23:0] BP_REGISTER_BASE = `HWBP_BASE_DEFAULT
)
(
   input  wire logic          clk,
   input  wire logic          rst_b,
   input  wire logic [23:0]   cpu_addr,
   input  wire hwbp_byte_type cpu_wdata,
   input  wire logic          cpu_read,
   input  wire logic          cpu_valid,
   output hwbp_byte_type      reg_rdata,
   output logic               reg_rsel,
   input  wire logic          escape_req_n,
   output logic               cpu_nmi_n,
   output logic               analyzer_trigger_n,
   input  wire hwbp_byte_type host_data_in,
   output hwbp_byte_type      host_data_out,
   output hwbp_byte_type      host_data_oe,
   input  wire logic          host_strobe_n,
   output logic               host_ack_n,
   input  wire hwbp_byte_type port_wdata,
   input  wire hwbp_byte_type port_dir,
   input  wire logic          port_ack_n,
   output hwbp_byte_type      port_rdata,
   output logic               port_strobe_n
);
   // ----------------------------------------
   // Input synchronisers for pins from the host
   // ----------------------------------------
   logic          esc_s1;
   logic          esc_s2;
   logic          stb_s1;
   logic          stb_s2;
   hwbp_byte_type hd_s1;
   hwbp_byte_type hd_s2;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         esc_s1 <= 1'b1;
         esc_s2 <= 1'b1;
         stb_s1 <= 1'b1;
         stb_s2 <= 1'b1;
         hd_s1  <= 8'h00;
         hd_s2  <= 8'h00;
      end else begin
         esc_s1 <= escape_req_n;
         esc_s2 <= esc_s1;
         stb_s1 <= host_strobe_n;
         stb_s2 <= stb_s1;
         hd_s1  <= host_data_in;
         hd_s2  <= hd_s1;
      end
   end

   // ----------------------------------------
   // Debug port toward the host
   // ----------------------------------------
   // The monitor steers the port through the processor-side port pins; the
   // data lines are two-way, one enable per line.
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         host_data_out <= 8'h00;
         host_data_oe  <= 8'h00;
         host_ack_n    <= 1'b1;
         port_rdata    <= 8'h00;
         port_strobe_n <= 1'b1;
      end else begin
         host_data_out <= port_wdata;
         host_data_oe  <= port_dir;
         host_ack_n    <= port_ack_n;
         port_rdata    <= hd_s2;
         port_strobe_n <= stb_s2;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic            in_window;
   hwbp_offset_type reg_ofs;
   logic            reg_wr;
   logic [23:0]     base_diff;

   assign base_diff = cpu_addr - BP_REGISTER_BASE;
   assign in_window = cpu_valid &&
                      (base_diff < 24'(`HWBP_REG_COUNT));
   assign reg_ofs   = base_diff[3:0];
   assign reg_wr    = in_window && !cpu_read;

   // ----------------------------------------
   // Register file and control register
   // ----------------------------------------
   logic [23:0]   bp_addr;
   hwbp_byte_type cmp_value;
   hwbp_byte_type file_rdata;
   logic [3:0]    ctrl;
   logic          status;
   logic          ctl_rd_q;
   logic          rd_q;
   logic          ctrl_wr;
   logic          hit;
   logic          esc_prev;
   logic          esc_fall;

   hwbp_regfile u_regs (
      .clk       (clk),
      .rst_b     (rst_b),
      .wr_en     (reg_wr),
      .wr_ofs    (reg_ofs),
      .wr_data   (cpu_wdata),
      .rd_ofs    (reg_ofs),
      .rd_data   (file_rdata),
      .bp_addr   (bp_addr),
      .cmp_value (cmp_value)
   );

   assign ctrl_wr = reg_wr && (reg_ofs == `HWBP_OFS_CONTROL);

   // ----------------------------------------
   // Hit detection
   // ----------------------------------------
   // Only 24 address bits exist; the top byte never takes part.
   logic addr_eq;
   logic dir_ok;
   logic data_eq;
   logic data_ok;

   assign addr_eq = (cpu_addr == bp_addr);
   assign dir_ok  = (cpu_read == ctrl[`HWBP_BIT_DIR_SEL]);
   assign data_eq = (cpu_wdata == cmp_value);
   assign data_ok = !ctrl[`HWBP_BIT_CMP_EN] ||
                    (data_eq == ctrl[`HWBP_BIT_MATCH]);
   assign hit     = cpu_valid && ctrl[`HWBP_BIT_ENABLE] &&
                    addr_eq && dir_ok && data_ok;
   assign esc_fall = esc_prev && !esc_s2;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl     <= 4'h0;
         status   <= 1'b0;
         ctl_rd_q <= 1'b0;
         rd_q     <= 1'b0;
         esc_prev <= 1'b1;
      end else begin
         esc_prev <= esc_s2;
         ctl_rd_q <= in_window && (reg_ofs == `HWBP_OFS_CONTROL);
         rd_q     <= in_window && cpu_read;
         if (ctrl_wr) begin
            ctrl <= cpu_wdata[3:0];
         end
         // A hit in the clearing cycle wins over the clear.
         if (hit) begin
            status <= 1'b1;
         end else if (ctrl_wr && !cpu_wdata[`HWBP_BIT_STATUS]) begin
            status <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Read data is assembled from the registered file output one cycle on,
   // so a read answers one edge after the edge that takes it.
   hwbp_byte_type ctrl_view;
   hwbp_byte_type next_reg_rdata;

   assign ctrl_view      = {status, 3'b000, ctrl};
   assign next_reg_rdata = !rd_q    ? 8'h00 :
                           ctl_rd_q ? ctrl_view : file_rdata;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cpu_nmi_n          <= 1'b1;
         analyzer_trigger_n <= 1'b1;
         reg_rdata          <= 8'h00;
         reg_rsel           <= 1'b0;
      end else begin
         cpu_nmi_n          <= !(hit || !esc_s2);
         analyzer_trigger_n <= !hit;
         reg_rsel           <= rd_q;
         reg_rdata          <= next_reg_rdata;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_nmi_one_cycle;
      @(posedge clk) disable iff (!rst_b)
      hit && !$past(hit) && esc_s2 && !$past(!esc_s2)
         |=> !cpu_nmi_n ##1 (cpu_nmi_n || $past(hit) || !$past(esc_s2));
   endproperty
   a_nmi_one_cycle: assert property (p_nmi_one_cycle)
      else $error("Interrupt not low for one cycle after hit.");

   property p_trigger;
      @(posedge clk) disable iff (!rst_b)
      hit |=> !analyzer_trigger_n;
   endproperty
   a_trigger: assert property (p_trigger)
      else $error("Trigger did not pulse on hit.");

   property p_trigger_cause;
      @(posedge clk) disable iff (!rst_b)
      !analyzer_trigger_n |-> $past(hit);
   endproperty
   a_trigger_cause: assert property (p_trigger_cause)
      else $error("Trigger pulsed without a hit.");

   property p_status_set;
      @(posedge clk) disable iff (!rst_b)
      hit |=> status;
   endproperty
   a_status_set: assert property (p_status_set)
      else $error("Status not set after hit.");

   property p_status_sticky;
      @(posedge clk) disable iff (!rst_b)
      status && !(ctrl_wr && !cpu_wdata[7]) |=> status;
   endproperty
   a_status_sticky: assert property (p_status_sticky)
      else $error("Status dropped without a clearing write.");

   property p_no_hit_disabled;
      @(posedge clk) disable iff (!rst_b)
      !ctrl[`HWBP_BIT_ENABLE] |-> !hit;
   endproperty
   a_no_hit_disabled: assert property (p_no_hit_disabled)
      else $error("Hit while detection disabled.");

   property p_escape_nmi;
      @(posedge clk) disable iff (!rst_b)
      !esc_s2 |=> !cpu_nmi_n;
   endproperty
   a_escape_nmi: assert property (p_escape_nmi)
      else $error("Escape request did not reach the interrupt.");

   property p_ctrl_write;
      @(posedge clk) disable iff (!rst_b)
      ctrl_wr |=> ctrl == $past(cpu_wdata[3:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("Control write not stored.");

   property p_read_select;
      @(posedge clk) disable iff (!rst_b)
      in_window && cpu_read |=> ##1 reg_rsel;
   endproperty
   a_read_select: assert property (p_read_select)
      else $error("Register read select did not follow a read.");

   property p_read_control;
      @(posedge clk) disable iff (!rst_b)
      rd_q && ctl_rd_q |=> reg_rdata == $past(ctrl_view);
   endproperty
   a_read_control: assert property (p_read_control)
      else $error("Control read did not return the control view.");

   c_hit: cover property (@(posedge clk) disable iff (!rst_b) hit);
   c_clear: cover property (@(posedge clk) disable iff (!rst_b)
      status ##1 !status);
   c_data_hit: cover property (@(posedge clk) disable iff (!rst_b)
      hit && ctrl[`HWBP_BIT_CMP_EN]);
   c_escape: cover property (@(posedge clk) disable iff (!rst_b) esc_fall);
endmodule

// ### tb/hwbp_cpu_model.sv
// ----------------------------------------
// Processor bus master seen by the unit
// ----------------------------------------
module hwbp_cpu_model
   import hwbp_pkg::*;
(
   input  wire logic     clk,
   output logic [23:0]   cpu_addr,
   output hwbp_byte_type cpu_wdata,
   output logic          cpu_read,
   output logic          cpu_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cpu_addr = 24'h000000;
      cpu_wdata = 8'h00;
      cpu_read = 1'b1;
      cpu_valid = 1'b0;
   end
   // The released bus shows inverted values, so stale data never matches.
   task automatic cycle(input logic [23:0] a, input hwbp_byte_type d,
                        input logic rd);
      @(posedge clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_read <= rd;
      cpu_valid <= 1'b1;
      @(posedge clk);
      cpu_valid <= 1'b0;
      cpu_addr <= ~a;
      cpu_wdata <= ~d;
   endtask
endmodule

// ### tb/test_hw_breakpoint_unit.sv
`include "hwbp_regs.svh"
module test_hw_breakpoint_unit
   import hwbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] BASE = 24'h0000D0;
   logic clk, rst_b, cpu_read, cpu_valid, escape_req_n, cpu_nmi_n;
   logic analyzer_trigger_n, reg_rsel, host_strobe_n, host_ack_n;
   logic port_ack_n, port_strobe_n;
   logic [23:0] cpu_addr;
   hwbp_byte_type cpu_wdata, reg_rdata, host_data_in, host_data_out;
   hwbp_byte_type host_data_oe, port_wdata, port_dir, port_rdata;
   int mismatches, comparisons, cycles;
   hw_breakpoint_unit #(.BP_REGISTER_BASE(BASE)) u_dut (
      .clk                (clk),
      .rst_b              (rst_b),
      .cpu_addr           (cpu_addr),
      .cpu_wdata          (cpu_wdata),
      .cpu_read           (cpu_read),
      .cpu_valid          (cpu_valid),
      .reg_rdata          (reg_rdata),
      .reg_rsel           (reg_rsel),
      .escape_req_n       (escape_req_n),
      .cpu_nmi_n          (cpu_nmi_n),
      .analyzer_trigger_n (analyzer_trigger_n),
      .host_data_in       (host_data_in),
      .host_data_out      (host_data_out),
      .host_data_oe       (host_data_oe),
      .host_strobe_n      (host_strobe_n),
      .host_ack_n         (host_ack_n),
      .port_wdata         (port_wdata),
      .port_dir           (port_dir),
      .port_ack_n         (port_ack_n),
      .port_rdata         (port_rdata),
      .port_strobe_n      (port_strobe_n)
   );
   hwbp_cpu_model u_cpu (.clk(clk), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata), .cpu_read(cpu_read), .cpu_valid(cpu_valid));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic finish_test();
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // The ceiling is far above the hundred or so cycles the run needs.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches = mismatches + 1;
         finish_test();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input hwbp_offset_type o, input hwbp_byte_type d);
      u_cpu.cycle(BASE + {20'h00000, o}, d, 1'b0);
   endtask
   task automatic rd(input hwbp_offset_type o, input hwbp_byte_type e);
      u_cpu.cycle(BASE + {20'h00000, o}, 8'h00, 1'b1);
      // Read data stands one edge after the edge that takes the read.
      @(posedge clk);
      #1;
      check(reg_rdata, e);
      check({7'h00, reg_rsel}, 8'h01);
   endtask
   // A hit shows on both outputs at the take edge, then ends one edge later.
   task automatic hit(input logic [23:0] a, input hwbp_byte_type d,
                      input logic r, input logic e);
      u_cpu.cycle(a, d, r);
      #1;
      check({7'h00, cpu_nmi_n}, {7'h00, ~e});
      check({7'h00, analyzer_trigger_n}, {7'h00, ~e});
      @(posedge clk);
      #1;
      check({7'h00, cpu_nmi_n}, 8'h01);
      check({7'h00, analyzer_trigger_n}, 8'h01);
   endtask
   task automatic t_reset();
      check({7'h00, cpu_nmi_n}, 8'h01);
      check(host_data_oe, 8'h00);
      rd(`HWBP_OFS_CONTROL, 8'h00);
      rd(`HWBP_OFS_ADDR_LOW, 8'h00);
   endtask
   task automatic t_address();
      wr(`HWBP_OFS_ADDR_LOW, 8'h00);
      wr(`HWBP_OFS_ADDR_MID, 8'h30);
      wr(`HWBP_OFS_ADDR_HIGH, 8'h00);
      wr(`HWBP_OFS_ADDR_TOP, 8'hFF);
      hit(24'h003000, 8'h00, 1'b0, 1'b0);
      wr(`HWBP_OFS_CONTROL, 8'h01);
      hit(24'h003000, 8'h00, 1'b0, 1'b1);
      rd(`HWBP_OFS_CONTROL, 8'h81);
      hit(24'h003000, 8'h00, 1'b1, 1'b0);
      hit(24'h013000, 8'h00, 1'b0, 1'b0);
      wr(`HWBP_OFS_CONTROL, 8'h01);
      rd(`HWBP_OFS_CONTROL, 8'h01);
      rd(`HWBP_OFS_ADDR_TOP, 8'h00);
      wr(`HWBP_OFS_ADDR_HIGH, 8'hFF);
      hit(24'hFF3000, 8'h00, 1'b0, 1'b1);
      wr(`HWBP_OFS_CONTROL, 8'h00);
      hit(24'hFF3000, 8'h00, 1'b0, 1'b0);
   endtask
   task automatic t_data();
      wr(`HWBP_OFS_CMP_LOW, 8'h55);
      wr(`HWBP_OFS_CMP_B1, 8'hAA);
      rd(`HWBP_OFS_CMP_B1, 8'h00);
      wr(`HWBP_OFS_CONTROL, 8'h0D);
      hit(24'hFF3000, 8'h55, 1'b0, 1'b1);
      hit(24'hFF3000, 8'h56, 1'b0, 1'b0);
      wr(`HWBP_OFS_CONTROL, 8'h05);
      hit(24'hFF3000, 8'h56, 1'b0, 1'b1);
      hit(24'hFF3000, 8'h55, 1'b0, 1'b0);
      wr(`HWBP_OFS_CONTROL, 8'h03);
      hit(24'hFF3000, 8'h00, 1'b1, 1'b1);
      hit(24'hFF3000, 8'h00, 1'b0, 1'b0);
   endtask
   task automatic t_escape();
      @(posedge clk);
      escape_req_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check({7'h00, cpu_nmi_n}, 8'h00);
      check({7'h00, analyzer_trigger_n}, 8'h01);
      @(posedge clk);
      escape_req_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      check({7'h00, cpu_nmi_n}, 8'h01);
   endtask
   task automatic t_port();
      @(posedge clk);
      port_wdata <= 8'hA5;
      port_dir <= 8'hF0;
      host_data_in <= 8'h3C;
      host_strobe_n <= 1'b0;
      port_ack_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check(host_data_out, 8'hA5);
      check(host_data_oe, 8'hF0);
      check(port_rdata, 8'h3C);
      check({7'h00, port_strobe_n}, 8'h00);
      check({7'h00, host_ack_n}, 8'h00);
   endtask
   initial begin
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      rst_b = 1'b0;
      escape_req_n = 1'b1;
      host_data_in = 8'h00;
      host_strobe_n = 1'b1;
      port_wdata = 8'h00;
      port_dir = 8'h00;
      port_ack_n = 1'b1;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_address();
      t_data();
      t_escape();
      t_port();
      finish_test();
   end
endmodule
